/* pcstk_defines.svh */
// Constants for the program counter and return stack block
//
// Overview of operation
// - Keep a 13-bit program counter; low byte register is readable and writable.
// - Upper counter bits are never read directly; software writes reach them only through the holding latch.
// - Every reset clears the program counter upper bits to zero.
// - A low byte write loads all five upper bits from latch bits four to zero.
// - Call or jump takes 11 bits from the instruction, two from latch bits four, three.
// - One contiguous 8K word program space, paged for call and jump.
// - Eight-entry 13-bit stack outside memory space; pointer hidden from software.
// - Push the counter plus one on every call and on interrupt vectoring.
// - Plain and interrupt returns pop the full 13-bit counter.
// - Stack pushes and pops never change the holding latch.
// - Stack is circular; ninth push overwrites the first entry.
// - No overflow or underflow status and no explicit push or pop commands.
`ifndef PCSTK_DEFINES_SVH
`define PCSTK_DEFINES_SVH

`define PCSTK_PC_W 13
`define PCSTK_LOW_W 8
`define PCSTK_UP_W 5
`define PCSTK_JMP_W 11
`define PCSTK_PAGE_LSB 3
`define PCSTK_PAGE_MSB 4
`define PCSTK_DEPTH 8
`define PCSTK_PTR_W 3
`define PCSTK_LATCH_W 5
`define PCSTK_PC_RST 13'h0000
`define PCSTK_LATCH_RST 5'h00
`define PCSTK_PTR_RST 3'h0
`define PCSTK_PTR_ONE 3'h1
`define PCSTK_PC_ONE 13'h0001
`define PCSTK_INT_VECTOR 13'h0004

`endif

/* pcstk_pkg.sv */
// Types shared by the program counter and return stack block
`include "pcstk_defines.svh"
package pcstk_pkg;
  typedef logic [`PCSTK_PC_W-1:0] pcstk_addr_t;
  typedef logic [`PCSTK_PTR_W-1:0] pcstk_ptr_t;

  // Sequencing operation requested by the decoder for one cycle
  typedef enum logic [2:0] {
    PCSTK_OP_NONE,
    PCSTK_OP_STEP,
    PCSTK_OP_LOW_WRITE,
    PCSTK_OP_JUMP,
    PCSTK_OP_CALL,
    PCSTK_OP_RETURN,
    PCSTK_OP_INTR
  } pcstk_op_e;
endpackage

/* pcstk_stack_if.sv */
// Interface between the sequencer and its return address memory
`timescale 1ns/10ps
interface pcstk_stack_if;
  logic wr_en;
  pcstk_pkg::pcstk_ptr_t wr_idx;
  pcstk_pkg::pcstk_addr_t wr_data;
  pcstk_pkg::pcstk_ptr_t rd_idx;
  pcstk_pkg::pcstk_addr_t rd_data;

  modport seq (output wr_en, output wr_idx, output wr_data, output rd_idx, input rd_data);
  modport mem (input wr_en, input wr_idx, input wr_data, input rd_idx, output rd_data);
endinterface

/* pcstk_stack_mem.sv */
// Eight-entry return address memory with registered read data
`timescale 1ns/10ps
`include "pcstk_defines.svh"
module pcstk_stack_mem (
  input wire logic clk_i,
  pcstk_stack_if.mem port_if
);
  typedef struct packed {
    logic [`PCSTK_DEPTH-1:0][`PCSTK_PC_W-1:0] entry;
    logic [`PCSTK_PC_W-1:0] rd;
  } pcstk_mem_s;

  pcstk_mem_s mem_ff;
  pcstk_mem_s nxt_mem;

  // Entries hold no reset value; a pop of an unwritten slot returns stale data
  always_comb begin
    nxt_mem = mem_ff;
    if (port_if.wr_en) begin
      nxt_mem.entry[port_if.wr_idx] = port_if.wr_data;
    end
    nxt_mem.rd = nxt_mem.entry[port_if.rd_idx];
  end

  always_ff @(posedge clk_i) begin
    mem_ff <= nxt_mem;
  end

  assign port_if.rd_data = mem_ff.rd;
endmodule

/* pcstk_top.sv */
// Program counter sequencer with holding latch, paging and circular return stack
`timescale 1ns/10ps
`include "pcstk_defines.svh"
module pcstk_top (
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire logic [2:0] op_i,
  input wire logic [`PCSTK_LOW_W-1:0] low_wr_data_i,
  input wire logic [`PCSTK_JMP_W-1:0] jump_target_i,
  input wire logic latch_wr_i,
  input wire logic [`PCSTK_LATCH_W-1:0] latch_wr_data_i,
  output logic [`PCSTK_PC_W-1:0] pc_o,
  output logic [`PCSTK_LOW_W-1:0] pc_low_byte_reg_o,
  output logic [`PCSTK_LATCH_W-1:0] pc_high_latch_o
);
  ////////////////////////////////////////////////////////////////////////////
  // Reset release
  logic rst_sync1_ff;
  logic rst_sync2_ff;

  // Two-stage release so the pc, latch and pointer registers leave reset on the same edge
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_sync1_ff <= 1'b0;
      rst_sync2_ff <= 1'b0;
    end else begin
      rst_sync1_ff <= 1'b1;
      rst_sync2_ff <= rst_sync1_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State
  typedef struct packed {
    logic [`PCSTK_PC_W-1:0] pc;
    logic [`PCSTK_LATCH_W-1:0] latch;
    logic [`PCSTK_PTR_W-1:0] ptr;
  } pcstk_state_s;

  pcstk_state_s st_ff;
  pcstk_state_s nxt_st;
  pcstk_pkg::pcstk_op_e op;
  pcstk_stack_if stk_if ();
  logic [`PCSTK_PTR_W-1:0] top_idx;

  assign op = pcstk_pkg::pcstk_op_e'(op_i);
  assign top_idx = st_ff.ptr - `PCSTK_PTR_ONE;

  pcstk_stack_mem u_mem (
    .clk_i(core_clk_i),
    .port_if(stk_if)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Stack port: pushes write at the pointer, read data always shows the top
  // The registered read tracks the pointer one cycle ahead, so a return sees
  // the entry on top; a push in the same cycle is forwarded, so a return may directly follow a push.
  always_comb begin
    stk_if.wr_en = (op == pcstk_pkg::PCSTK_OP_CALL) || (op == pcstk_pkg::PCSTK_OP_INTR);
    stk_if.wr_idx = st_ff.ptr;
    stk_if.wr_data = st_ff.pc + `PCSTK_PC_ONE; // Return lands after the call
    stk_if.rd_idx = nxt_st.ptr - `PCSTK_PTR_ONE;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencing; the pointer has no software path and no overflow flag
  always_comb begin
    nxt_st = st_ff;
    // Latch writes apply first so a same-cycle low byte write sees them
    if (latch_wr_i) begin
      nxt_st.latch = latch_wr_data_i;
    end
    case (op)
      pcstk_pkg::PCSTK_OP_NONE: begin
        nxt_st.pc = st_ff.pc;
      end
      pcstk_pkg::PCSTK_OP_STEP: begin
        nxt_st.pc = st_ff.pc + `PCSTK_PC_ONE;
      end
      pcstk_pkg::PCSTK_OP_LOW_WRITE: begin
        nxt_st.pc = {nxt_st.latch[`PCSTK_UP_W-1:0], low_wr_data_i};
      end
      pcstk_pkg::PCSTK_OP_JUMP: begin
        nxt_st.pc = {nxt_st.latch[`PCSTK_PAGE_MSB:`PCSTK_PAGE_LSB], jump_target_i};
      end
      pcstk_pkg::PCSTK_OP_CALL: begin
        nxt_st.pc = {nxt_st.latch[`PCSTK_PAGE_MSB:`PCSTK_PAGE_LSB], jump_target_i};
        nxt_st.ptr = st_ff.ptr + `PCSTK_PTR_ONE;
      end
      pcstk_pkg::PCSTK_OP_INTR: begin
        nxt_st.pc = `PCSTK_INT_VECTOR;
        nxt_st.ptr = st_ff.ptr + `PCSTK_PTR_ONE;
      end
      pcstk_pkg::PCSTK_OP_RETURN: begin
        nxt_st.pc = stk_if.rd_data;
        nxt_st.ptr = top_idx;
      end
      default: begin
        nxt_st.pc = st_ff.pc;
      end
    endcase
  end

  // Upper bits and pointer cleared on every reset
  always_ff @(posedge core_clk_i or negedge rst_sync2_ff) begin
    if (!rst_sync2_ff) begin
      st_ff.pc <= `PCSTK_PC_RST;
      st_ff.latch <= `PCSTK_LATCH_RST;
      st_ff.ptr <= `PCSTK_PTR_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs; the upper counter bits reach software only via pc_o fetch path
  always_comb begin
    pc_o = st_ff.pc;
    pc_low_byte_reg_o = st_ff.pc[`PCSTK_LOW_W-1:0];
    pc_high_latch_o = st_ff.latch;
  end
endmodule

/* pcstk_chk.sv */
// Assertion checker bound to the program counter and return stack top
`timescale 1ns/10ps
module pcstk_chk (
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire logic [2:0] op_i,
  input wire logic [7:0] low_wr_data_i,
  input wire logic [10:0] jump_target_i,
  input wire logic latch_wr_i,
  input wire logic [4:0] latch_wr_data_i,
  input wire logic [12:0] pc_o,
  input wire logic [7:0] pc_low_byte_reg_o,
  input wire logic [4:0] pc_high_latch_o
);
  logic [1:0] rel_ff;
  logic live;
  logic [4:0] lat;
  // Ops are ignored for two edges while the internal reset copy is low
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) rel_ff <= 2'h0;
    else if (!rel_ff[1]) rel_ff <= rel_ff + 2'h1;
  end
  assign live = rel_ff[1];
  // A latch write in the same cycle is already seen by the load
  assign lat = latch_wr_i ? latch_wr_data_i : pc_high_latch_o;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);
  ////////////////////////////////
  a_low_write_load: assert property (
    live && op_i == 3'h2 |=> pc_o == {$past(lat), $past(low_wr_data_i)}) else $error("low load");
  a_branch_page: assert property (
    live && (op_i == 3'h3 || op_i == 3'h4) |=> pc_o == {$past(lat[4:3]), $past(jump_target_i)})
    else $error("branch page");
  a_low_byte_view: assert property (pc_low_byte_reg_o == pc_o[7:0]) else $error("low view");
  a_latch_untouched: assert property (
    live && op_i > 3'h3 && op_i < 3'h7 && !latch_wr_i |=> $stable(pc_high_latch_o))
    else $error("latch moved");
  a_reset_clear: assert property (
    !live |-> pc_o == 13'h0000 && pc_high_latch_o == 5'h00) else $error("reset value");
  a_call_return: assert property (
    live && op_i == 3'h4 ##1 op_i == 3'h0 ##1 op_i == 3'h5 |=> pc_o == $past(pc_o, 3) + 13'h0001)
    else $error("call return");
  a_intr_vector: assert property (live && op_i == 3'h6 |=> pc_o == 13'h0004)
    else $error("vector");
  a_step_count: assert property (live && op_i == 3'h1 |=> pc_o == $past(pc_o) + 13'h0001)
    else $error("step");
  a_idle_hold: assert property (live && (op_i == 3'h0 || op_i == 3'h7) |=> $stable(pc_o))
    else $error("idle moved");
  c_call_ret: cover property (live && op_i == 3'h4 ##1 op_i == 3'h0 ##1 op_i == 3'h5);
  c_intr: cover property (live && op_i == 3'h6);
  c_low_wr: cover property (live && op_i == 3'h2 && latch_wr_i);
endmodule
bind pcstk_top pcstk_chk u_pcstk_chk (.core_clk_i, .rstn_i, .op_i, .low_wr_data_i, .jump_target_i,
  .latch_wr_i, .latch_wr_data_i, .pc_o, .pc_low_byte_reg_o, .pc_high_latch_o);

/* pcstk_dec_model.sv */
// Decoder model that presents one operation per core clock
`timescale 1ns/10ps
module pcstk_dec_model (
  input wire logic clk_i,
  output logic [2:0] op_o = 3'h0,
  output logic [7:0] low_o = 8'h00,
  output logic [10:0] tgt_o = 11'h000,
  output logic lwr_o = 1'b0,
  output logic [4:0] ldat_o = 5'h00
);
  // Launch after an edge so the next edge takes it; hold for one cycle
  task automatic issue(input logic [2:0] o, input logic [10:0] t, input logic [4:0] l,
    input logic w);
    @(posedge clk_i);
    op_o <= o;
    tgt_o <= t;
    low_o <= t[7:0];
    lwr_o <= w;
    ldat_o <= l;
    #1;
  endtask
endmodule

/* testbench.sv */
// Self-checking bench for the program counter and return stack
`timescale 1ns/10ps
`define CHK(n, e, s) begin tests_run++; if ((s) !== (e)) begin n_mismatch++; \
  $display("ERROR %s exp %h got %h", n, e, s); end end
module testbench;
  logic core_clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic [2:0] op;
  logic [7:0] low;
  logic [10:0] tgt;
  logic lwr;
  logic [4:0] ldat;
  logic [12:0] pc;
  logic [7:0] pc_low_byte_reg;
  logic [4:0] lat;
  int n_mismatch = 0;
  int tests_run = 0;
  pcstk_top u_pcstk_top (.core_clk_i(core_clk_i), .rstn_i(rstn_i), .op_i(op), .low_wr_data_i(low),
    .jump_target_i(tgt), .latch_wr_i(lwr), .latch_wr_data_i(ldat), .pc_o(pc),
    .pc_low_byte_reg_o(pc_low_byte_reg), .pc_high_latch_o(lat));
  pcstk_dec_model u_pcstk_dec_model (.clk_i(core_clk_i), .op_o(op), .low_o(low), .tgt_o(tgt),
    .lwr_o(lwr), .ldat_o(ldat));
  // 50 MHz core clock
  initial forever #10 core_clk_i = ~core_clk_i;
  ////////////////////////////////
  task automatic go(input logic [2:0] o, input logic [10:0] t = 0, input logic [4:0] l = 0,
    input logic w = 0);
    u_pcstk_dec_model.issue(o, t, l, w);
  endtask
  function automatic logic [12:0] tg(input int i);
    return {2'h3, 11'h040 + 11'(i) * 11'h081};
  endfunction
  task automatic results();
    if (n_mismatch == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  ////////////////////////////////
  task automatic t_reset();
    repeat (5) @(posedge core_clk_i);
    rstn_i <= 1'b1;
    go(0);
    go(0);
    `CHK("pc", 13'h0000, pc)
    `CHK("latch", 5'h00, lat)
  endtask
  // Every page, then a low write whose latch lands in the same cycle
  task automatic t_page();
    for (int p = 0; p < 4; p++) begin
      go(3, 11'h7FF - 11'(p), {2'(p), 3'h5}, 1);
      go(0);
      `CHK("jump", {2'(p), 11'h7FF - 11'(p)}, pc)
    end
    go(2, 11'h0FE, 5'h15, 1);
    go(1);
    `CHK("low write", 13'h15FE, pc)
    `CHK("low view", 8'hFE, pc_low_byte_reg)
    go(7);
    `CHK("step", 13'h15FF, pc)
    go(0);
    `CHK("bad op", 13'h15FF, pc)
  endtask
  // Nine calls wrap the stack; then nine pops, the last of an empty stack
  task automatic t_stack();
    for (int i = 0; i < 9; i++) go(4, 11'(tg(i)), 5'h18, 1);
    go(0, 0, 5'h0A, 1);
    for (int j = 0; j < 9; j++) begin
      go(5);
      go(0);
      `CHK("pop", tg(j == 8 ? 7 : 7 - j) + 13'h0001, pc)
    end
    `CHK("latch kept", 5'h0A, lat)
    go(6);
    go(0);
    `CHK("vector", 13'h0004, pc)
    go(5);
    go(0);
    `CHK("int return", tg(7) + 13'h0002, pc)
  endtask
  initial begin
    t_reset();
    t_page();
    t_stack();
    results();
  end
  // Watchdog far beyond the fifty-odd cycles the tests need
  initial begin
    #100000;
    n_mismatch++;
    results();
  end
endmodule
